// ===== listen_duty_cycle_controller.sv
/*
  Wake-up duty-cycle controller with a classic Wishbone register slave and
  one level interrupt. Assumes radio status inputs come from logic on clk_i,
  so they are read without synchronisers.
*/
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "wakeup_consts.svh"

module listen_duty_cycle_controller
  import wakeup_pkg::*;
#(
  parameter logic [`PERIOD_W-1:0] MID_TICK_CYC  = `RES_MID_CYC,
  parameter logic [`PERIOD_W-1:0] SLOW_TICK_CYC = `RES_SLOW_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [`ADR_W-1:0]  wb_adr_i,
  input  wire logic [`SEL_W-1:0]  wb_sel_i,
  input  wire logic [`DAT_W-1:0]  wb_dat_i,
  output logic      [`DAT_W-1:0]  wb_dat_o,
  output logic                    wb_ack_o,
  input  wire radio_status_t      radio_i,
  output logic      [2:0]         chip_mode_o,
  output logic                    rx_enable_o,
  output logic                    buffer_flush_o,
  output logic                    wakeup_active_o,
  output logic                    irq_o
);

  timing_ctrl_t       timing;
  logic [`COEF_W-1:0] idle_coef;
  logic [`COEF_W-1:0] rx_coef;
  logic               wakeup_enable;
  logic [2:0]         mode_sel;
  logic [`IRQ_W-1:0]  irq_status;
  logic [`IRQ_W-1:0]  irq_mask;
  logic [`IRQ_W-1:0]  irq_event;
  logic [`IRQ_W-1:0]  irq_clear;

  wakeup_state_t      state;
  wakeup_state_t      next_state;
  logic [2:0]         stop_mode;
  logic [2:0]         next_chip_mode;

  logic               bus_req;
  logic               wr_strobe;
  logic [`IDX_W-1:0]  index;
  op_mode_t           wr_opm;
  timing_ctrl_t       wr_timing;
  logic [7:0]         read_byte;
  logic               abort_req;

  logic               accept;
  logic               frame_end;
  logic               phase_load;
  logic               phase_tick;
  logic               phase_expired;
  logic [1:0]         res_sel;
  logic [`PERIOD_W-1:0] tick_period;
  logic [`COEF_W-1:0] load_coef;

  // Bus decode; registers sit in the low byte of each aligned word
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_strobe = bus_req && wb_we_i && wb_sel_i[0];
  assign index     = wb_adr_i[`ADR_W-1:2];
  assign wr_opm    = op_mode_t'(wb_dat_i[7:0]);
  assign wr_timing = timing_ctrl_t'(wb_dat_i[7:0]);

  // Abort only counts when enable is written low in the same access
  assign abort_req = wr_strobe && (index == `IDX_OP_MODE)
                     && wr_opm.wakeup_abort && !wr_opm.wakeup_enable;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_comb begin
    case (index)
      `IDX_OP_MODE: begin
        read_byte = {1'b0, wakeup_enable, 1'b0, chip_mode_o, 2'b00};
      end
      `IDX_TIMING: begin
        read_byte = {timing[7:1], 1'b0};
      end
      `IDX_IDLE_COEF: begin
        read_byte = idle_coef;
      end
      `IDX_RX_COEF: begin
        read_byte = rx_coef;
      end
      `IDX_IRQ_STATUS: begin
        read_byte = {5'h00, irq_status};
      end
      `IDX_IRQ_MASK: begin
        read_byte = {5'h00, irq_mask};
      end
      `IDX_PHASE: begin
        read_byte = {5'h00, state};
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= {24'h000000, read_byte};
    end
  end

  // Timing control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timing <= timing_ctrl_t'(`RST_TIMING);
    end else if (wr_strobe && (index == `IDX_TIMING)) begin
      timing        <= wr_timing;
      timing.unused <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_coef <= `RST_IDLE_COEF;
    end else if (wr_strobe && (index == `IDX_IDLE_COEF)) begin
      idle_coef <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_coef <= `RST_RX_COEF;
    end else if (wr_strobe && (index == `IDX_RX_COEF)) begin
      rx_coef <= wb_dat_i[7:0];
    end
  end

  // Operating-mode register; the abort bit is never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wakeup_enable <= 1'b0;
      mode_sel      <= `RST_MODE;
    end else if (wr_strobe && (index == `IDX_OP_MODE)) begin
      wakeup_enable <= wr_opm.wakeup_enable;
      mode_sel      <= wr_opm.mode;
    end
  end

  // Acceptance and end-of-frame terms
  assign accept = radio_i.rssi_above
                  && (!timing.acceptance_criterion || radio_i.sync_word_match);
  assign frame_end = radio_i.payload_complete_flag || radio_i.rx_timeout;

  // Phase sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        // Enable is trusted to arrive from standby; no check is made here
        if (wakeup_enable) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (phase_expired) begin
          next_state = ST_RX;
        end
      end
      ST_RX: begin
        if (accept) begin
          if ((timing.end_action == `END_GO_MODE)
              || (timing.end_action == `END_RESUME)) begin
            next_state = ST_HOLD;
          end else begin
            next_state = ST_STOPPED;
          end
        end else if (phase_expired) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (frame_end) begin
          if (timing.end_action == `END_RESUME) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_STOPPED;
          end
        end
      end
      ST_STOPPED: begin
        // Stays put until software clears enable
        if (!wakeup_enable) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (abort_req) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Mode held once cycling stops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_mode <= `RST_MODE;
    end else if ((next_state == ST_STOPPED) && (state == ST_RX)) begin
      stop_mode <= `MODE_RX;
    end else if ((next_state == ST_STOPPED) && (state == ST_HOLD)) begin
      stop_mode <= mode_sel;
    end
  end

  // A new phase restarts both the divider and the coefficient count
  assign phase_load = (next_state != state)
                      && ((next_state == ST_IDLE) || (next_state == ST_RX));
  assign res_sel    = (next_state == ST_RX) ? timing.receive_tick_resolution
                                            : timing.idle_tick_resolution;
  assign load_coef  = (next_state == ST_RX) ? rx_coef : idle_coef;

  // Reserved resolution 00 falls back to the finest tick
  always_comb begin
    case (res_sel)
      `RES_MID: begin
        tick_period = MID_TICK_CYC;
      end
      `RES_SLOW: begin
        tick_period = SLOW_TICK_CYC;
      end
      default: begin
        tick_period = `RES_FAST_CYC;
      end
    endcase
  end

  tick_divider u_tick (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (phase_load),
    .period_i  (tick_period),
    .tick_o    (phase_tick)
  );

  phase_counter u_phase (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (phase_load),
    .coef_i    (load_coef),
    .tick_i    (phase_tick),
    .expired_o (phase_expired)
  );

  // Chip mode seen by the radio; idle phases sleep to save power
  always_comb begin
    case (state)
      ST_IDLE: begin
        next_chip_mode = `MODE_SLEEP;
      end
      ST_RX, ST_HOLD: begin
        next_chip_mode = `MODE_RX;
      end
      ST_STOPPED: begin
        next_chip_mode = stop_mode;
      end
      default: begin
        next_chip_mode = mode_sel;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_mode_o     <= `RST_MODE;
      rx_enable_o     <= 1'b0;
      wakeup_active_o <= 1'b0;
    end else begin
      chip_mode_o     <= next_chip_mode;
      rx_enable_o     <= (next_chip_mode == `MODE_RX);
      wakeup_active_o <= (state != ST_OFF);
    end
  end

  // Flush on every receive wake-up under resume, so stale data never mixes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_flush_o <= 1'b0;
    end else begin
      buffer_flush_o <= phase_load && (next_state == ST_RX)
                        && (timing.end_action == `END_RESUME);
    end
  end

  // Interrupt events
  always_comb begin
    irq_event                  = '0;
    irq_event[`IRQ_ACCEPT]     = (state == ST_RX) && accept;
    irq_event[`IRQ_RX_EXPIRED] = (state == ST_RX) && !accept && phase_expired;
    irq_event[`IRQ_STOPPED]    = (next_state == ST_STOPPED) && (state != ST_STOPPED);
  end

  assign irq_clear = (wr_strobe && (index == `IDX_IRQ_STATUS))
                     ? wb_dat_i[`IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= `RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= `RST_IRQ;
    end else if (wr_strobe && (index == `IDX_IRQ_MASK)) begin
      irq_mask <= wb_dat_i[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

endmodule : listen_duty_cycle_controller

// ===== listen_duty_cycle_controller_tb_top.sv
/* Self-checking bench for the wake-up duty-cycle controller.
   Assumes shortened tick parameters and drives the radio status itself. */
`timescale 1ns/1ps
`include "wakeup_consts.svh"
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module listen_duty_cycle_controller_tb_top
  import wakeup_pkg::*;
;
  localparam logic [`PERIOD_W-1:0] MID  = 22'h14;
  localparam logic [`PERIOD_W-1:0] SLOW = 22'h28;
  logic              clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0, wb_ack_o, rx_enable_o, buffer_flush_o, wakeup_active_o, irq_o;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [2:0]        chip_mode_o;
  radio_status_t     radio_i = '0;
  int                errors = 0, samples_checked = 0, n;
  int                tick [4] = '{640, 640, 20, 40};
  always #50 clk_i = ~clk_i;
  listen_duty_cycle_controller #(.MID_TICK_CYC(MID), .SLOW_TICK_CYC(SLOW))
    u_listen_duty_cycle_controller (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .radio_i(radio_i), .chip_mode_o(chip_mode_o),
    .rx_enable_o(rx_enable_o), .buffer_flush_o(buffer_flush_o),
    .wakeup_active_o(wakeup_active_o), .irq_o(irq_o));
  task automatic final_report;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // Holds the request until ack is sampled; read data is taken at that edge
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      errors++;
      final_report();
    end
  endtask : xfer
  task automatic rd_check(input logic [5:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHECK("register read", {24'h0, e}, rd)
  endtask : rd_check
  // Polls the phase register; a bound keeps a stuck phase from hanging the run
  task automatic wait_state(input logic [2:0] st);
    int k;
    k = 0;
    do begin
      xfer(1'b0, `IDX_PHASE, 8'h00);
      k++;
    end while (rd[2:0] !== st && k < 1000);
    `CHECK("phase state", st, rd[2:0])
  endtask : wait_state
  task automatic time_until(input logic [2:0] m);
    n = 0;
    while (chip_mode_o !== m && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
  endtask : time_until
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_check(`IDX_TIMING, 8'h92);
    rd_check(`IDX_IDLE_COEF, 8'hF5);
    rd_check(`IDX_RX_COEF, 8'h20);
    rd_check(`IDX_OP_MODE, 8'h04);
    xfer(1'b1, `IDX_TIMING, 8'hFF);
    rd_check(`IDX_TIMING, 8'hFE);
    xfer(1'b1, 6'h30, 8'hFF);
    rd_check(6'h30, 8'h00);
    xfer(1'b1, `IDX_IDLE_COEF, 8'h02);
    xfer(1'b1, `IDX_RX_COEF, 8'h03);
    for (int r = 1; r < 4; r++) begin
      xfer(1'b1, `IDX_TIMING, {2'(r), 2'b11, 1'b0, 2'b10, 1'b0});
      // Enable only from standby; the tick oscillator is left untouched meanwhile
      `CHECK("standby before enable", 3'h1, chip_mode_o)
      xfer(1'b1, `IDX_OP_MODE, 8'h44);
      time_until(`MODE_RX);
      `CHECK("idle length", 1'b1, (n >= 2 * tick[r] - 2 && n <= 2 * tick[r] + 4))
      time_until(`MODE_SLEEP);
      `CHECK("receive length", 1'b1, (n >= 118 && n <= 124))
      xfer(1'b1, `IDX_OP_MODE, 8'h24);
      wait_state(3'h0);
      `CHECK("cycling stopped", 1'b0, wakeup_active_o)
      rd_check(`IDX_OP_MODE, 8'h04);
    end
    rd_check(`IDX_IRQ_STATUS, 8'h02);
    `CHECK("irq masked", 1'b0, irq_o)
    xfer(1'b1, `IDX_IRQ_MASK, 8'h07);
    repeat (2) @(posedge clk_i);
    `CHECK("irq raised", 1'b1, irq_o)
    xfer(1'b1, `IDX_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge clk_i);
    `CHECK("irq cleared", 1'b0, irq_o)
    // End actions 00, 01 and 10; the middle case accepts on strength alone
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `IDX_TIMING, {2'b10, 2'b11, i != 1, 2'(i), 1'b0});
      xfer(1'b1, `IDX_RX_COEF, 8'h20);
      `CHECK("standby before enable", 3'h1, chip_mode_o)
      xfer(1'b1, `IDX_OP_MODE, 8'h44);
      wait_state(3'h2);
      if (i != 1) begin
        radio_i <= radio_status_t'(4'h8);
        rd_check(`IDX_PHASE, 8'h02);
      end
      radio_i <= radio_status_t'((i == 1) ? 4'h8 : 4'hC);
      wait_state((i == 0) ? 3'h4 : 3'h3);
      radio_i <= radio_status_t'(4'h2);
      `CHECK("mode after accept", `MODE_RX, chip_mode_o)
      `CHECK("receiver enable", 1'b1, rx_enable_o)
      `CHECK("cycling active", 1'b1, wakeup_active_o)
      wait_state((i == 2) ? 3'h1 : 3'h4);
      radio_i <= '0;
      if (i == 1) `CHECK("mode after payload", 3'h1, chip_mode_o)
      if (i == 2) begin
        n = 0;
        while (buffer_flush_o !== 1'b1 && n < 300) begin
          @(posedge clk_i);
          n++;
        end
        `CHECK("flush at wake-up", 1'b1, buffer_flush_o)
      end
      rd_check(`IDX_IRQ_STATUS, (i == 2) ? 8'h01 : 8'h05);
      xfer(1'b1, `IDX_IRQ_STATUS, 8'h07);
      xfer(1'b1, `IDX_OP_MODE, (i == 2) ? 8'h24 : 8'h04);
      wait_state(3'h0);
      `CHECK("cycling ended", 1'b0, wakeup_active_o)
    end
    final_report();
  end
endmodule : listen_duty_cycle_controller_tb_top

// ===== listen_properties.sv
/* Port assertions for the wake-up duty-cycle controller.
   Assumes it is bound to listen_duty_cycle_controller and sees only its ports. */
`timescale 1ns/1ps
`include "wakeup_consts.svh"
module listen_properties
  import wakeup_pkg::*;
#(
  parameter logic [`PERIOD_W-1:0] MID_TICK_CYC  = `RES_MID_CYC,
  parameter logic [`PERIOD_W-1:0] SLOW_TICK_CYC = `RES_SLOW_CYC
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [`ADR_W-1:0] wb_adr_i,
  input wire logic [`SEL_W-1:0] wb_sel_i,
  input wire logic [`DAT_W-1:0] wb_dat_i,
  input wire logic [`DAT_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o,
  input wire radio_status_t     radio_i,
  input wire logic [2:0]        chip_mode_o,
  input wire logic              rx_enable_o,
  input wire logic              buffer_flush_o,
  input wire logic              wakeup_active_o,
  input wire logic              irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_op_req;
    s_req ##0 wb_adr_i[7:2] == `IDX_OP_MODE;
  endsequence
  sequence s_abort;
    s_op_req ##0 wb_we_i && wb_sel_i[0] && wb_dat_i[6:5] == 2'b01;
  endsequence
  a_ack_one_cycle: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a single pulse after a request");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_abort_stops: assert property (s_abort |-> ##[1:3] !wakeup_active_o)
    else $error("abort did not end duty cycling");
  a_abort_reads_zero: assert property (s_op_req ##0 !wb_we_i |=> !wb_dat_o[5])
    else $error("abort bit read back as one");
  a_rx_mode_match: assert property (rx_enable_o == (chip_mode_o == `MODE_RX))
    else $error("receiver enable disagrees with chip mode");
  a_flush_pulse: assert property (buffer_flush_o |=> !buffer_flush_o)
    else $error("flush longer than one cycle");
  a_flush_at_rx: assert property (buffer_flush_o |-> ##[0:2] rx_enable_o)
    else $error("flush without receive wake-up");
  a_idle_active: assert property (chip_mode_o == `MODE_SLEEP |-> wakeup_active_o)
    else $error("idle phase while cycling is off");
endmodule : listen_properties

bind listen_duty_cycle_controller listen_properties #(
  .MID_TICK_CYC(MID_TICK_CYC), .SLOW_TICK_CYC(SLOW_TICK_CYC)
) u_listen_properties (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .radio_i(radio_i), .chip_mode_o(chip_mode_o),
  .rx_enable_o(rx_enable_o), .buffer_flush_o(buffer_flush_o),
  .wakeup_active_o(wakeup_active_o), .irq_o(irq_o)
);

// ===== phase_counter.sv
/*
  Phase counter: counts coefficient ticks after a load and pulses at expiry.
  Assumes ticks come from the tick divider restarted with the same load.
*/
`timescale 1ns/1ps
`include "wakeup_consts.svh"

module phase_counter
  import wakeup_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               load_i,
  input  wire logic [`COEF_W-1:0] coef_i,
  input  wire logic               tick_i,
  output logic                    expired_o
);

  logic [`COEF_W-1:0] remaining;
  logic               armed;
  logic               last_tick;

  // A zero coefficient ends at the first tick rather than wrapping to 256
  assign last_tick = tick_i && armed && (remaining <= `COEF_W'(1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remaining <= '0;
      armed     <= 1'b0;
    end else if (load_i) begin
      remaining <= coef_i;
      armed     <= 1'b1;
    end else if (last_tick) begin
      armed     <= 1'b0;
    end else if (tick_i && armed) begin
      remaining <= remaining - `COEF_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= last_tick && !load_i;
    end
  end

endmodule : phase_counter

// ===== tick_divider.sv
/*
  Tick divider: one-cycle tick every period_i clocks, restartable.
  Assumes period_i is at least one and stays steady within a phase.
*/
`timescale 1ns/1ps
`include "wakeup_consts.svh"

module tick_divider
  import wakeup_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 restart_i,
  input  wire logic [`PERIOD_W-1:0] period_i,
  output logic                      tick_o
);

  logic [`PERIOD_W-1:0] count;
  logic                 wrap;

  // Compare with >= so a shorter period written mid-phase cannot run past
  assign wrap = (count >= period_i - `PERIOD_W'(1));

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || wrap) begin
      count <= '0;
    end else begin
      count <= count + `PERIOD_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap && !restart_i;
    end
  end

endmodule : tick_divider

// ===== wakeup_consts.svh
/*
  Constants for the wake-up duty-cycle controller: register indexes, reset values,
  field codes and timing figures. Assumes a 10 MHz system clock.
*/
`ifndef WAKEUP_CONSTS_SVH
`define WAKEUP_CONSTS_SVH

`define ADR_W          8
`define DAT_W          32
`define SEL_W          4
`define IDX_W          6
`define COEF_W         8
`define PERIOD_W       22
`define IRQ_W          3

`define IDX_OP_MODE    6'h01
`define IDX_TIMING     6'h0D
`define IDX_IDLE_COEF  6'h0E
`define IDX_RX_COEF    6'h0F
`define IDX_IRQ_STATUS 6'h20
`define IDX_IRQ_MASK   6'h21
`define IDX_PHASE      6'h22

`define RST_TIMING     8'h92
`define RST_IDLE_COEF  8'hF5
`define RST_RX_COEF    8'h20
`define RST_MODE       3'h1
`define RST_IRQ        3'h0

`define RES_FAST       2'h1
`define RES_MID        2'h2
`define RES_SLOW       2'h3

`define END_STAY       2'h0
`define END_GO_MODE    2'h1
`define END_RESUME     2'h2

`define MODE_SLEEP     3'h0
`define MODE_RX        3'h4

`define IRQ_ACCEPT     0
`define IRQ_RX_EXPIRED 1
`define IRQ_STOPPED    2

`define CLK_PERIOD_NS  100
`define RES_FAST_NS    64000
`define RES_MID_NS     4100000
`define RES_SLOW_NS    262000000
`define RES_FAST_CYC   (`PERIOD_W'(`RES_FAST_NS / `CLK_PERIOD_NS))
`define RES_MID_CYC    (`PERIOD_W'(`RES_MID_NS / `CLK_PERIOD_NS))
`define RES_SLOW_CYC   (`PERIOD_W'(`RES_SLOW_NS / `CLK_PERIOD_NS))

`endif

// ===== wakeup_pkg.sv
/*
  Types for the wake-up duty-cycle controller: phase states and register layouts.
  Assumes nothing beyond the constants header.
*/
package wakeup_pkg;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_IDLE    = 3'b001,
    ST_RX      = 3'b010,
    ST_HOLD    = 3'b011,
    ST_STOPPED = 3'b100
  } wakeup_state_t;

  typedef struct packed {
    logic [1:0] idle_tick_resolution;
    logic [1:0] receive_tick_resolution;
    logic       acceptance_criterion;
    logic [1:0] end_action;
    logic       unused;
  } timing_ctrl_t;

  typedef struct packed {
    logic       seq_off;
    logic       wakeup_enable;
    logic       wakeup_abort;
    logic [2:0] mode;
    logic [1:0] unused;
  } op_mode_t;

  typedef struct packed {
    logic rssi_above;
    logic sync_word_match;
    logic payload_complete_flag;
    logic rx_timeout;
  } radio_status_t;

endpackage : wakeup_pkg
